// ### bench/isr_ctl_model.sv
`default_nettype none
module isr_ctl_model
    import isr_pkg::*;
(
    // clock
    input  wire logic                 clk,
    // command side
    output logic                      cmd_valid,
    output isr_req_t                  cmd,
    // answer side
    input  wire logic                 rsp_valid_q,
    input  wire logic [ISR_GRP_W-1:0] rsp_data_q
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    // answer caught at a falling edge, where it has settled
    task automatic xfer(input isr_cmd_t c, input logic [15:0] w,
                        output logic [15:0] d, output bit to);
        int n;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd       = '{code: c, wdata: w};
        @(negedge clk);
        cmd_valid = 1'b0;
        // released fields must not echo the last request
        cmd       = isr_req_t'(~cmd);
        n = 0;
        while (rsp_valid_q !== 1'b1 && n < 8)
        begin
            @(negedge clk);
            n++;
        end
        d  = rsp_data_q;
        to = (rsp_valid_q !== 1'b1);
    endtask
endmodule // isr_ctl_model
`default_nettype wire

// ### bench/tb_top.sv
`default_nettype none
module tb_top
    import isr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // short queue so that filling it stays quick
    localparam int QD = 4;

    logic                 clk;
    logic                 nrst;
    isr_circ_t            circ;
    isr_std_src_t         std_src;
    logic                 cmd_valid;
    isr_req_t             cmd;
    logic                 rsp_valid_q;
    logic [ISR_GRP_W-1:0] rsp_data_q;
    logic                 mq_valid;
    logic [ISR_MSG_W-1:0] mq_data;
    logic                 mq_ready;
    logic                 srq_o;
    logic                 srq_oe_n_q;
    wire logic            srq_line;
    int                   errors;
    int                   checks_done;
    logic                 q;
    isr_cmd_t             cc;
    isr_cmd_t             ce;
    int                   pin_tab [8] = '{7, 6, 5, 4, 3, 2, 1, 0};
    int                   bit_tab [8] = '{0, 3, 4, 0, 1, 3, 9, 12};
    int                   src_tab [5] = '{4, 3, 2, 1, 0};
    int                   std_tab [5] = '{0, 2, 3, 4, 5};

    // open-drain wire with its pull-up
    assign srq_line = srq_oe_n_q ? 1'b1 : srq_o;

    initial
    begin
        clk = 1'b0;
    end

    always #5 clk = ~clk;

    isr_status_core #(.QDEPTH(QD)) DUT (
        .clk         (clk),
        .nrst        (nrst),
        .circ_i      (circ),
        .std_src_i   (std_src),
        .cmd_valid   (cmd_valid),
        .cmd         (cmd),
        .rsp_valid_q (rsp_valid_q),
        .rsp_data_q  (rsp_data_q),
        .mq_valid    (mq_valid),
        .mq_data     (mq_data),
        .mq_ready    (mq_ready),
        .srq_o       (srq_o),
        .srq_oe_n_q  (srq_oe_n_q)
    );

    isr_ctl_model ctl (
        .clk         (clk),
        .cmd_valid   (cmd_valid),
        .cmd         (cmd),
        .rsp_valid_q (rsp_valid_q),
        .rsp_data_q  (rsp_data_q)
    );

    task automatic chk(input string nm, input logic [15:0] got,
                       input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic xfer(input isr_cmd_t c, input logic [15:0] w,
                        output logic [15:0] r);
        bit to;
        ctl.xfer(c, w, r, to);
        if (to)
        begin
            errors++;
            $display("ERROR answer expected 1 seen 0");
            give_verdict();
        end
    endtask

    task automatic rc(input string nm, input isr_cmd_t c,
                      input logic [15:0] exp);
        logic [15:0] r;
        xfer(c, 16'h0000, r);
        chk(nm, r, exp);
    endtask

    task automatic wr(input isr_cmd_t c, input logic [15:0] w);
        logic [15:0] r;
        xfer(c, w, r);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    initial
    begin
        nrst        = 1'b0;
        circ        = '0;
        std_src     = '0;
        mq_valid    = 1'b0;
        mq_data     = 8'h00;
        errors      = 0;
        checks_done = 0;
        idle(3);
        nrst = 1'b1;

        chk("srq idle", {15'h0000, srq_line}, 16'h0001);
        rc("operation_summary en", CMD_RD_OPERATION_SUMMARY_EN, 16'h0000);
        rc("ques en", CMD_RD_QUES_EN, 16'h0000);
        rc("std en", CMD_RD_STD_EN, 16'h0000);
        rc("sre", CMD_RD_SRE, 16'h0000);
        rc("operation_summary evt", CMD_RD_OPERATION_SUMMARY_EVT, 16'h0000);
        rc("ques evt", CMD_RD_QUES_EVT, 16'h0000);
        rc("stb", CMD_RD_STB, 16'h0000);
        rc("std evt", CMD_RD_STD_EVT, 16'h0080);
        rc("std evt", CMD_RD_STD_EVT, 16'h0000);
        $display("test reset done");

        wr(CMD_WR_OPERATION_SUMMARY_EN, 16'h0019);
        wr(CMD_WR_QUES_EN, 16'h120b);
        wr(CMD_WR_STD_EN, 16'h00bd);
        wr(CMD_WR_SRE, 16'h00b8);
        rc("operation_summary en", CMD_RD_OPERATION_SUMMARY_EN, 16'h0019);
        rc("ques en", CMD_RD_QUES_EN, 16'h120b);
        rc("std en", CMD_RD_STD_EN, 16'h00bd);
        rc("sre", CMD_RD_SRE, 16'h00b8);
        wr(CMD_WR_SRE, 16'h0000);
        $display("test enables done");

        for (int i = 0; i < 8; i++)
        begin
            q  = (i > 2);
            cc = q ? CMD_RD_QUES_COND : CMD_RD_OPERATION_SUMMARY_COND;
            ce = q ? CMD_RD_QUES_EVT : CMD_RD_OPERATION_SUMMARY_EVT;
            circ[pin_tab[i]] = 1'b1;
            idle(4);
            rc("cond", cc, 16'h0001 << bit_tab[i]);
            circ[pin_tab[i]] = 1'b0;
            idle(4);
            rc("cond", cc, 16'h0000);
            rc("sum", CMD_RD_STB, q ? 16'h0008 : 16'h0080);
            rc("evt", ce, 16'h0001 << bit_tab[i]);
            rc("evt", ce, 16'h0000);
            rc("sum", CMD_RD_STB, 16'h0000);
        end
        wr(CMD_WR_QUES_EN, 16'h0001);
        circ.overcurrent_trip = 1'b1;
        idle(4);
        circ.overcurrent_trip = 1'b0;
        rc("masked", CMD_RD_STB, 16'h0000);
        rc("evt", CMD_RD_QUES_EVT, 16'h0002);
        $display("test groups done");

        for (int i = 0; i < 5; i++)
        begin
            std_src[src_tab[i]] = 1'b1;
            idle(1);
            std_src = '0;
            idle(2);
            rc("esb", CMD_RD_STB, 16'h0020);
            rc("std", CMD_RD_STD_EVT, 16'h0001 << std_tab[i]);
            rc("esb", CMD_RD_STB, 16'h0000);
        end
        $display("test std done");

        wr(CMD_WR_SRE, 16'h0020);
        std_src.command_error = 1'b1;
        idle(1);
        std_src = '0;
        idle(3);
        chk("srq", {15'h0000, srq_line}, 16'h0000);
        rc("mss", CMD_RD_STB, 16'h0060);
        rc("mss", CMD_RD_STB, 16'h0060);
        rc("poll", CMD_SERIAL_POLL, 16'h0060);
        chk("srq", {15'h0000, srq_line}, 16'h0001);
        rc("poll", CMD_SERIAL_POLL, 16'h0020);
        rc("std", CMD_RD_STD_EVT, 16'h0020);
        wr(CMD_WR_SRE, 16'h0000);
        $display("test srq done");

        // one push more than fits: the last must be refused
        for (int i = 0; i <= QD; i++)
        begin
            chk("ready", {15'h0000, mq_ready}, {15'h0000, i < QD});
            mq_valid = 1'b1;
            mq_data  = 8'h10 + 8'(i);
            idle(1);
        end
        mq_valid = 1'b0;
        mq_data  = ~mq_data;
        rc("mav", CMD_RD_STB, 16'h0010);
        for (int i = 0; i < QD; i++)
            rc("queue", CMD_RD_QUEUE, 16'h0010 + 16'(i));
        rc("queue", CMD_RD_QUEUE, 16'h0000);
        rc("mav", CMD_RD_STB, 16'h0000);
        $display("test queue done");

        // second power-up: masks left set above must be gone again
        nrst = 1'b0;
        idle(2);
        nrst = 1'b1;
        chk("srq idle", {15'h0000, srq_line}, 16'h0001);
        rc("operation_summary en", CMD_RD_OPERATION_SUMMARY_EN, 16'h0000);
        rc("ques en", CMD_RD_QUES_EN, 16'h0000);
        rc("std en", CMD_RD_STD_EN, 16'h0000);
        rc("std evt", CMD_RD_STD_EVT, 16'h0080);
        rc("stb", CMD_RD_STB, 16'h0000);
        $display("test power-up done");

        give_verdict();
    end
endmodule // tb_top
`default_nettype wire

// ### hw/isr_pkg.sv
`default_nettype none
package isr_pkg;

    localparam int ISR_GRP_W = 16;
    localparam int ISR_STB_W = 8;
    localparam int ISR_MSG_W = 8;
    localparam int ISR_QDEPTH = 16;

    // operation group bit positions
    localparam int OPERATION_SUMMARY_CAL_BIT  = 0;
    localparam int OPERATION_SUMMARY_TRAN_BIT = 3;
    localparam int OPERATION_SUMMARY_MEASUREMENT_DONE_BIT = 4;

    // questionable group bit positions (bit 14 left unused)
    localparam int QUES_OV_BIT   = 0;
    localparam int QUES_OCP_BIT  = 1;
    localparam int QUES_OT_BIT   = 3;
    localparam int QUES_RSD_BIT  = 9;
    localparam int QUES_IRMS_BIT = 12;

    // standard event bit positions
    localparam int STD_OPC_BIT = 0;
    localparam int STD_QYE_BIT = 2;
    localparam int STD_DDE_BIT = 3;
    localparam int STD_EXE_BIT = 4;
    localparam int STD_CME_BIT = 5;
    localparam int STD_PON_BIT = 7;

    // status byte bit positions
    localparam int STB_QUES_BIT = 3;
    localparam int STB_MAV_BIT  = 4;
    localparam int STB_ESB_BIT  = 5;
    localparam int STB_RQS_BIT  = 6;
    localparam int STB_OPERATION_SUMMARY_BIT = 7;

    // reset values
    localparam logic [ISR_GRP_W-1:0] GRP_RST     = 16'h0000;
    localparam logic [ISR_STB_W-1:0] STB_ZERO    = 8'h00;
    localparam logic [ISR_STB_W-1:0] STD_EVT_RST = 8'h80;

    typedef enum logic [3:0] {
        CMD_RD_OPERATION_SUMMARY_COND = 4'h0,
        CMD_RD_OPERATION_SUMMARY_EVT  = 4'h1,
        CMD_RD_OPERATION_SUMMARY_EN   = 4'h2,
        CMD_WR_OPERATION_SUMMARY_EN   = 4'h3,
        CMD_RD_QUES_COND = 4'h4,
        CMD_RD_QUES_EVT  = 4'h5,
        CMD_RD_QUES_EN   = 4'h6,
        CMD_WR_QUES_EN   = 4'h7,
        CMD_RD_STD_EVT   = 4'h8,
        CMD_RD_STD_EN    = 4'h9,
        CMD_WR_STD_EN    = 4'ha,
        CMD_RD_STB       = 4'hb,
        CMD_RD_SRE       = 4'hc,
        CMD_WR_SRE       = 4'hd,
        CMD_RD_QUEUE     = 4'he,
        CMD_SERIAL_POLL  = 4'hf
    } isr_cmd_t;

    typedef struct packed {
        isr_cmd_t               code;
        logic [ISR_GRP_W-1:0]   wdata;
    } isr_req_t;

    // monitored circuit levels, asynchronous to clk
    typedef struct packed {
        logic cal_done;
        logic transient_done;
        logic measurement_done;
        logic output_voltage_fault;
        logic overcurrent_trip;
        logic overtemperature;
        logic remote_shutdown_active;
        logic rms_current_limit;
    } isr_circ_t;

    // one-cycle pulses from the command parser
    typedef struct packed {
        logic op_complete;
        logic query_error;
        logic device_error;
        logic exec_error;
        logic command_error;
    } isr_std_src_t;

endpackage : isr_pkg
`default_nettype wire

// ### hw/isr_queue_mem.sv
`default_nettype none
module isr_queue_mem #(
    parameter int W  = 8,
    parameter int D  = 16,
    parameter int AW = $clog2(D)
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // read side
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data_q
);

    logic [W-1:0] mem [D];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_data_q <= '0;
        end
        else if (rd_en)
        begin
            rd_data_q <= mem[rd_addr];
        end
    end

endmodule // isr_queue_mem
`default_nettype wire

// ### hw/isr_status_core.sv
// Behaviour
// RL1 - operation group: calibration done bit 0, transient 3, measurement 4
// RL2 - questionable: voltage 0, overcurrent 1, overtemp 3, shutdown 9, rms 12
// RL3 - standard event latches OPC 0, QYE 2, DDE 3, EXE 4, CME 5, PON 7
// RL4 - status byte: ques 3, message 4, event 5, summary/request 6, operation_summary 7
// RL5 - condition registers mirror live circuit state and are read-only
// RL6 - event registers latch until read; a read returns then clears
// RL7 - enable registers are read/write per-bit masks into group summary
// RL8 - status byte bit 3 is OR of enabled questionable events
// RL9 - standard event enable mask, set by command, forms event summary
// RL10 - power-on bit of standard event set at every power-up
// RL11 - status byte query returns live summary in bit 6, clears nothing
// RL12 - serial poll returns latched request bit 6 then clears it
// RL13 - master summary is unlatched OR of service-enabled status bits
// RL14 - requesting service drives SRQ and latches request bit 6
// RL15 - serial poll leaves other status byte bits untouched
// RL16 - output queue holds message bytes first-in first-out until read
// RL17 - message available bit set while queue is non-empty
// RL18 - status byte bit 7 is OR of enabled operation events
// RL19 - power-on clears all status data and all enable masks; reset sets power-on bit 7 of the standard event register
// RL20 - reading an event register also drops its summary contribution
// RL21 - event bit sets when condition rises, stays until read
`default_nettype none
module isr_status_core
    import isr_pkg::*;
#(
    parameter int QDEPTH = ISR_QDEPTH
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // monitored circuits
    input  wire isr_circ_t            circ_i,
    // parser events, same clock
    input  wire isr_std_src_t         std_src_i,
    // controller command and answer
    input  wire logic                 cmd_valid,
    input  wire isr_req_t             cmd,
    output logic                      rsp_valid_q,
    output logic     [ISR_GRP_W-1:0]  rsp_data_q,
    // output queue fill side
    input  wire logic                 mq_valid,
    input  wire logic [ISR_MSG_W-1:0] mq_data,
    output logic                      mq_ready,
    // service request pin, open drain
    output logic                      srq_o,
    output logic                      srq_oe_n_q
);

    localparam int AW = $clog2(QDEPTH);
    localparam logic [AW:0] QFULL  = (AW+1)'(QDEPTH);
    localparam logic [AW:0] QEMPTY = '0;

    isr_circ_t circ_s1_q, circ_s2_q, circ_p_q;
    logic [ISR_GRP_W-1:0] operation_summary_cond, operation_summary_prev, ques_cond, ques_prev;
    logic [ISR_GRP_W-1:0] operation_summary_evt_q, operation_summary_en_q, ques_evt_q, ques_en_q;
    logic [ISR_STB_W-1:0] std_evt_q, std_en_q, std_set, sre_q, stb_base;
    logic operation_summary_sum, ques_sum, esb, mav, mss, mss_p_q, rqs_q;
    logic [AW-1:0] wr_ptr_q, rd_ptr_q;
    logic [AW:0] count_q;
    logic [ISR_MSG_W-1:0] q_rdata;
    logic push, pop;
    logic stage_v_q, stage_q_rd_q;
    logic [ISR_GRP_W-1:0] stage_q;

    function automatic logic is_cmd(isr_cmd_t c);
        return cmd_valid && (cmd.code == c);
    endfunction

    // pins are asynchronous; the second stage gives the level, the third the previous level
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            circ_s1_q <= '0;
            circ_s2_q <= '0;
            circ_p_q  <= '0;
        end
        else
        begin
            circ_s1_q <= circ_i;
            circ_s2_q <= circ_s1_q;
            circ_p_q  <= circ_s2_q;
        end
    end

    always_comb
    begin
        operation_summary_cond = GRP_RST;
        operation_summary_prev = GRP_RST;
        ques_cond = GRP_RST;
        ques_prev = GRP_RST;
        operation_summary_cond[OPERATION_SUMMARY_CAL_BIT]  = circ_s2_q.cal_done;         // [RL1] [RL5]
        operation_summary_cond[OPERATION_SUMMARY_TRAN_BIT] = circ_s2_q.transient_done;   // [RL1]
        operation_summary_cond[OPERATION_SUMMARY_MEASUREMENT_DONE_BIT] = circ_s2_q.measurement_done; // [RL1]
        operation_summary_prev[OPERATION_SUMMARY_CAL_BIT]  = circ_p_q.cal_done;
        operation_summary_prev[OPERATION_SUMMARY_TRAN_BIT] = circ_p_q.transient_done;
        operation_summary_prev[OPERATION_SUMMARY_MEASUREMENT_DONE_BIT] = circ_p_q.measurement_done;
        ques_cond[QUES_OV_BIT]   = circ_s2_q.output_voltage_fault; // [RL2]
        ques_cond[QUES_OCP_BIT]  = circ_s2_q.overcurrent_trip;     // [RL2]
        ques_cond[QUES_OT_BIT]   = circ_s2_q.overtemperature;      // [RL2]
        ques_cond[QUES_RSD_BIT]  = circ_s2_q.remote_shutdown_active; // [RL2]
        ques_cond[QUES_IRMS_BIT] = circ_s2_q.rms_current_limit;    // [RL2]
        ques_prev[QUES_OV_BIT]   = circ_p_q.output_voltage_fault;
        ques_prev[QUES_OCP_BIT]  = circ_p_q.overcurrent_trip;
        ques_prev[QUES_OT_BIT]   = circ_p_q.overtemperature;
        ques_prev[QUES_RSD_BIT]  = circ_p_q.remote_shutdown_active;
        ques_prev[QUES_IRMS_BIT] = circ_p_q.rms_current_limit;
        std_set = STB_ZERO;
        std_set[STD_OPC_BIT] = std_src_i.op_complete;   // [RL3]
        std_set[STD_QYE_BIT] = std_src_i.query_error;   // [RL3]
        std_set[STD_DDE_BIT] = std_src_i.device_error;  // [RL3]
        std_set[STD_EXE_BIT] = std_src_i.exec_error;    // [RL3]
        std_set[STD_CME_BIT] = std_src_i.command_error; // [RL3]
    end

    // a rising edge in the clearing cycle still survives the read
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            operation_summary_evt_q <= GRP_RST;                              // [RL19]
            ques_evt_q <= GRP_RST;
        end
        else
        begin
            operation_summary_evt_q <= (is_cmd(CMD_RD_OPERATION_SUMMARY_EVT) ? GRP_RST : operation_summary_evt_q)
                          | (operation_summary_cond & ~operation_summary_prev);     // [RL6] [RL21]
            ques_evt_q <= (is_cmd(CMD_RD_QUES_EVT) ? GRP_RST : ques_evt_q)
                          | (ques_cond & ~ques_prev);     // [RL6] [RL21]
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            std_evt_q <= STD_EVT_RST;                    // [RL10] [RL19]
        end
        else
        begin
            std_evt_q <= (is_cmd(CMD_RD_STD_EVT) ? STB_ZERO : std_evt_q)
                         | std_set;                              // [RL6]
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            operation_summary_en_q <= GRP_RST;                               // [RL19]
            ques_en_q <= GRP_RST;
            std_en_q  <= STB_ZERO;
            sre_q     <= STB_ZERO;
        end
        else
        begin
            if (is_cmd(CMD_WR_OPERATION_SUMMARY_EN))
            begin
                operation_summary_en_q <= cmd.wdata;                          // [RL7]
            end
            if (is_cmd(CMD_WR_QUES_EN))
            begin
                ques_en_q <= cmd.wdata;                          // [RL7]
            end
            if (is_cmd(CMD_WR_STD_EN))
            begin
                std_en_q <= cmd.wdata[ISR_STB_W-1:0];            // [RL9]
            end
            if (is_cmd(CMD_WR_SRE))
            begin
                sre_q <= cmd.wdata[ISR_STB_W-1:0];
            end
        end
    end

    // summaries follow the latched events, so a clearing read drops them
    assign operation_summary_sum = |(operation_summary_evt_q & operation_summary_en_q);          // [RL18] [RL20]
    assign ques_sum = |(ques_evt_q & ques_en_q);          // [RL8] [RL20]
    assign esb      = |(std_evt_q & std_en_q);            // [RL9]
    assign mav      = (count_q != QEMPTY);                // [RL17]

    always_comb
    begin
        stb_base = STB_ZERO;
        stb_base[STB_QUES_BIT] = ques_sum;                // [RL4]
        stb_base[STB_MAV_BIT]  = mav;                     // [RL4]
        stb_base[STB_ESB_BIT]  = esb;                     // [RL4]
        stb_base[STB_OPERATION_SUMMARY_BIT] = operation_summary_sum;                // [RL4]
    end

    // bit 6 of the enable is ignored: stb_base holds zero there
    assign mss = |(stb_base & sre_q);                     // [RL13]

    // request latches on a new reason; set wins over the poll clear
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mss_p_q    <= 1'b0;
            rqs_q      <= 1'b0;
            srq_oe_n_q <= 1'b1;
        end
        else
        begin
            mss_p_q <= mss;
            if (mss && !mss_p_q)
            begin
                rqs_q      <= 1'b1;                       // [RL14]
                srq_oe_n_q <= 1'b0;
            end
            else if (is_cmd(CMD_SERIAL_POLL))
            begin
                rqs_q      <= 1'b0;                       // [RL12] [RL15]
                srq_oe_n_q <= 1'b1;
            end
        end
    end

    assign srq_o = 1'b0;

    assign push     = mq_valid && mq_ready;
    assign pop      = is_cmd(CMD_RD_QUEUE) && mav;
    assign mq_ready = (count_q != QFULL);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= QEMPTY;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + AW'(1);            // [RL16]
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + AW'(1);            // [RL16]
            end
            if (push && !pop)
            begin
                count_q <= count_q + (AW+1)'(1);
            end
            else if (pop && !push)
            begin
                count_q <= count_q - (AW+1)'(1);
            end
        end
    end

    isr_queue_mem #(
        .W (ISR_MSG_W),
        .D (QDEPTH),
        .AW(AW)
    ) u_queue (
        .clk      (clk),
        .nrst     (nrst),
        .wr_en    (push),
        .wr_addr  (wr_ptr_q),
        .wr_data  (mq_data),
        .rd_en    (pop),
        .rd_addr  (rd_ptr_q),
        .rd_data_q(q_rdata)
    );

    // reads sample the state before any clear taken in the same edge
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage_v_q    <= 1'b0;
            stage_q_rd_q <= 1'b0;
            stage_q      <= GRP_RST;
        end
        else
        begin
            stage_v_q    <= cmd_valid;
            stage_q_rd_q <= pop;
            stage_q      <= GRP_RST;
            case (cmd.code)
                CMD_RD_OPERATION_SUMMARY_COND: stage_q <= operation_summary_cond;   // [RL5]
                CMD_RD_OPERATION_SUMMARY_EVT:  stage_q <= operation_summary_evt_q;  // [RL6]
                CMD_RD_OPERATION_SUMMARY_EN:   stage_q <= operation_summary_en_q;   // [RL7]
                CMD_RD_QUES_COND: stage_q <= ques_cond;   // [RL5]
                CMD_RD_QUES_EVT:  stage_q <= ques_evt_q;  // [RL6]
                CMD_RD_QUES_EN:   stage_q <= ques_en_q;   // [RL7]
                CMD_RD_STD_EVT:   stage_q[ISR_STB_W-1:0] <= std_evt_q;
                CMD_RD_STD_EN:    stage_q[ISR_STB_W-1:0] <= std_en_q;
                CMD_RD_SRE:       stage_q[ISR_STB_W-1:0] <= sre_q;
                CMD_RD_STB:
                begin
                    stage_q[ISR_STB_W-1:0] <= stb_base;
                    stage_q[STB_RQS_BIT]   <= mss;        // [RL11]
                end
                CMD_SERIAL_POLL:
                begin
                    stage_q[ISR_STB_W-1:0] <= stb_base;
                    stage_q[STB_RQS_BIT]   <= rqs_q;      // [RL12]
                end
                default: stage_q <= GRP_RST;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= GRP_RST;
        end
        else
        begin
            rsp_valid_q <= stage_v_q;
            rsp_data_q  <= stage_q_rd_q ? {8'h00, q_rdata} : stage_q;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_EVT_SET: assert property ( // [RL21]
        (operation_summary_cond[OPERATION_SUMMARY_MEASUREMENT_DONE_BIT] && !operation_summary_prev[OPERATION_SUMMARY_MEASUREMENT_DONE_BIT])
        |=> operation_summary_evt_q[OPERATION_SUMMARY_MEASUREMENT_DONE_BIT])
        else $error("operation event not set on rising condition");
    AST_EVT_HOLD: assert property ( // [RL6]
        (ques_evt_q[QUES_OCP_BIT] && !is_cmd(CMD_RD_QUES_EVT))
        |=> ques_evt_q[QUES_OCP_BIT])
        else $error("questionable event dropped without a read");
    AST_RD_RET: assert property ( // [RL6]
        is_cmd(CMD_RD_OPERATION_SUMMARY_EVT)
        |-> ##2 (rsp_valid_q && rsp_data_q == $past(operation_summary_evt_q, 2)))
        else $error("event read returned wrong value");
    AST_RD_CLR: assert property ( // [RL20]
        (is_cmd(CMD_RD_QUES_EVT) && (ques_cond & ~ques_prev) == GRP_RST)
        |=> (ques_evt_q == GRP_RST && !ques_sum))
        else $error("event read did not clear or summary stayed");
    AST_QUES_SUM: assert property ( // [RL8]
        is_cmd(CMD_RD_STB) |-> ##2
        rsp_data_q[STB_QUES_BIT] == |($past(ques_evt_q & ques_en_q, 2)))
        else $error("questionable summary missing");
    AST_OPERATION_SUMMARY_SUM: assert property ( // [RL18]
        is_cmd(CMD_RD_STB) |-> ##2
        rsp_data_q[STB_OPERATION_SUMMARY_BIT] == |($past(operation_summary_evt_q & operation_summary_en_q, 2)))
        else $error("operation summary wrong in status byte");
    AST_STB_MSS: assert property ( // [RL11]
        is_cmd(CMD_RD_STB) |-> ##2
        (rsp_data_q[STB_RQS_BIT] == $past(mss, 2)))
        else $error("status query bit 6 not live summary");
    AST_POLL_CLR: assert property ( // [RL12]
        (is_cmd(CMD_SERIAL_POLL) && !(mss && !mss_p_q))
        |=> (!rqs_q && srq_oe_n_q))
        else $error("serial poll did not clear request");
    AST_SRQ: assert property ( // [RL14]
        (mss && !mss_p_q) |=> (rqs_q && !srq_oe_n_q) [*1])
        else $error("service request not raised");
    AST_MAV: assert property ( // [RL17]
        push && count_q == QEMPTY |=> stb_base[STB_MAV_BIT])
        else $error("message available not set after push");
    AST_STB_KEEP: assert property ( // [RL15]
        is_cmd(CMD_SERIAL_POLL) |-> ##2
        rsp_data_q[STB_ESB_BIT] == $past(esb, 2))
        else $error("serial poll disturbed event summary bit");

    COV_POLL: cover property (rqs_q ##1 is_cmd(CMD_SERIAL_POLL));
    COV_FULL: cover property (count_q == QFULL && mq_valid);
    COV_QRD:  cover property (pop ##2 rsp_valid_q);
    COV_PON:  cover property (std_evt_q[STD_PON_BIT] && std_en_q[STD_PON_BIT]);

endmodule // isr_status_core
`default_nettype wire
